// *** irm_pkg.sv ***
// Shared constants and types of the ingress flow-control block
package irm_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int NPORT = 53;
  localparam int PW = 6;
  localparam int CW = 14;
  localparam int AW = 13;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [AW-1:0] OFS_GPON = 13'h000;
  localparam logic [AW-1:0] OFS_GPOFF = 13'h004;
  localparam logic [AW-1:0] OFS_GDROP = 13'h008;
  localparam logic [AW-1:0] OFS_SPUSED = 13'h00c;
  localparam logic [AW-1:0] OFS_DROPCNT = 13'h010;
  localparam logic [AW-1:0] OFS_STATE = 13'h014;
  localparam logic [1:0] PORT_REGION = 2'h2;
  localparam int PORT_SHIFT = 5;
  localparam logic [2:0] PSEL_RSV = 3'h0;
  localparam logic [2:0] PSEL_PON = 3'h1;
  localparam logic [2:0] PSEL_POFF = 3'h2;
  localparam logic [2:0] PSEL_PDROP = 3'h3;
  localparam logic [2:0] PSEL_PSET = 3'h4;
  localparam logic [2:0] PSEL_DROPEN = 3'h5;
  localparam logic [2:0] PSEL_USED = 3'h6;

  // ----------------------------------------------------------------
  // Reset values and bus answers
  // ----------------------------------------------------------------
  localparam logic [CW-1:0] RST_CELLS = 14'h0000;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  // Threshold register: level [13:0], enable bit 16, trip bit 17
  typedef struct packed {
    logic [13:0] rsvd_hi;
    logic trip;
    logic en;
    logic [1:0] rsvd_lo;
    logic [CW-1:0] level;
  } irm_thr_s;

  // Port pause settings: enable bit 0, force bit 1, pattern bit 2
  typedef struct packed {
    logic [28:0] rsvd;
    logic pattern;
    logic force_on;
    logic en;
  } irm_pset_s;

  // Cell written to the buffer by a source port
  typedef struct packed {
    logic valid;
    logic last;
    logic [PW-1:0] port;
  } irm_cell_s;

  // Cell handed back to the free list
  typedef struct packed {
    logic valid;
    logic [PW-1:0] port;
  } irm_free_s;

endpackage

// *** irm_ingress_flow_ctrl.sv ***
// Ingress buffer accounting, pause state vector and tail-drop decisions
`timescale 1ns/1ps

module irm_ingress_flow_ctrl (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Buffer events from the core
  input wire irm_pkg::irm_cell_s cell_in,
  input wire irm_pkg::irm_free_s free_in,
  // Decisions and pause vector toward the MACs
  output logic decision_valid_q,
  output logic drop_q,
  output logic [irm_pkg::PW-1:0] decision_port_q,
  output logic [irm_pkg::NPORT-1:0] pause_vec_q,
  // AXI4-Lite write
  input wire logic [irm_pkg::AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [irm_pkg::AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  import irm_pkg::*;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Shared-pool part of a port's usage, zero while inside reserve
  function automatic logic [CW-1:0] pool_use(input logic [CW-1:0] used,
                                             input logic [CW-1:0] rsv);
    pool_use = (used > rsv) ? used - rsv : RST_CELLS;
  endfunction

  // Fires at or above level, or when tripped
  function automatic logic hit_ge(input irm_thr_s t, input logic [CW-1:0] v);
    hit_ge = t.en && (v >= t.level || t.trip);
  endfunction

  // Fires strictly above level, or when tripped
  function automatic logic hit_gt(input irm_thr_s t, input logic [CW-1:0] v);
    hit_gt = t.en && (v > t.level || t.trip);
  endfunction

  // Release condition of a pause-off level
  function automatic logic hit_lt(input irm_thr_s t, input logic [CW-1:0] v);
    hit_lt = t.en && (v < t.level || t.trip);
  endfunction

  // Byte-lane merge of a write into an old word
  function automatic logic [31:0] wmerge(input logic [31:0] old,
                                         input logic [31:0] nw,
                                         input logic [3:0] st);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (st[b]) begin
        r[8*b +: 8] = nw[8*b +: 8];
      end
    end
    wmerge = r;
  endfunction

  // Keep only the defined threshold fields
  function automatic irm_thr_s to_thr(input logic [31:0] w);
    irm_thr_s t;
    t = irm_thr_s'(w);
    t.rsvd_hi = '0;
    t.rsvd_lo = '0;
    to_thr = t;
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  irm_thr_s gpon_q, gpoff_q, gdrop_q;
  irm_thr_s pon_q [NPORT];
  irm_thr_s poff_q [NPORT];
  irm_thr_s pdrop_q [NPORT];
  irm_pset_s pset_q [NPORT];
  logic [CW-1:0] rsv_q [NPORT];
  logic [CW-1:0] used_q [NPORT];
  logic [NPORT-1:0] dropen_q;
  logic [NPORT-1:0] ppause_q;
  logic [CW-1:0] sp_used_q, sp_used_d;
  logic gpause_q;
  logic [31:0] drop_cnt_q;

  // ----------------------------------------------------------------
  // Cell accounting
  // ----------------------------------------------------------------
  // Out-of-range ports are ignored so arrays are never overrun
  wire a_ok = cell_in.valid && (cell_in.port < PW'(NPORT));
  wire f_ok = free_in.valid && (free_in.port < PW'(NPORT));
  wire [PW-1:0] a_idx = a_ok ? cell_in.port : '0;
  wire [PW-1:0] f_idx = f_ok ? free_in.port : '0;
  wire [CW-1:0] a_used = used_q[a_idx];
  wire [CW-1:0] a_rsv = rsv_q[a_idx];
  wire [CW-1:0] a_pool = pool_use(a_used, a_rsv);
  wire a_to_pool = a_ok && (a_used >= a_rsv);
  wire f_from_pool = f_ok && (used_q[f_idx] > rsv_q[f_idx]);
  wire a_last = a_ok && cell_in.last;

  // Alloc and free on one port cancel; the pool share stays unchanged
  wire same_port = a_ok && f_ok && (a_idx == f_idx);

  // Shared-pool total; frees of dropped packets come back here too
  assign sp_used_d = same_port ? sp_used_q :
                     sp_used_q + CW'(a_to_pool) - CW'(f_from_pool);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sp_used_q <= RST_CELLS;
    end else begin
      sp_used_q <= sp_used_d;
    end
  end

  // ----------------------------------------------------------------
  // Tail-drop decision at the last cell
  // ----------------------------------------------------------------
  // Strict compare on counts before the last cell lets in a packet whose last cell arrives at the level
  wire rsv_left = a_used < a_rsv;
  wire g_drop = hit_gt(gdrop_q, sp_used_q) && !rsv_left;
  wire p_drop = hit_gt(pdrop_q[a_idx], a_pool);
  wire drop_d = a_last && dropen_q[a_idx] && (g_drop || p_drop);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      decision_valid_q <= 1'b0;
      drop_q <= 1'b0;
      decision_port_q <= '0;
      drop_cnt_q <= RST_WORD;
    end else begin
      decision_valid_q <= a_last;
      drop_q <= drop_d;
      decision_port_q <= a_idx;
      drop_cnt_q <= drop_cnt_q + 32'(drop_d);
    end
  end

  // ----------------------------------------------------------------
  // Global pause with hysteresis
  // ----------------------------------------------------------------
  // Set waits for a last cell; release is watched every cycle so an
  // idle port still unpauses as cells drain away
  wire gp_set = a_last && hit_ge(gpon_q, sp_used_q);
  wire gp_clr = hit_lt(gpoff_q, sp_used_q);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gpause_q <= 1'b0;
    end else if (gp_set) begin
      gpause_q <= 1'b1;
    end else if (gp_clr) begin
      gpause_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite handshake
  // ----------------------------------------------------------------
  // Address and data are taken together, one transfer at a time
  wire wr_start = s_axi_awvalid && s_axi_wvalid && !s_axi_awready &&
                  !s_axi_bvalid;
  wire wr_take = s_axi_awvalid && s_axi_wvalid && s_axi_awready;
  wire rd_start = s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
  wire rd_take = s_axi_arvalid && s_axi_arready;

  // Write decode
  wire [AW-1:0] wa = s_axi_awaddr;
  wire [PW-1:0] wport = wa[PORT_SHIFT +: PW];
  wire [2:0] wsel = wa[4:2];
  wire w_al = (wa[1:0] == 2'h0);
  wire w_preg = w_al && (wa[AW-1 -: 2] == PORT_REGION) &&
                (wport < PW'(NPORT)) && (wsel <= PSEL_DROPEN);
  wire w_greg = (wa == OFS_GPON) || (wa == OFS_GPOFF) || (wa == OFS_GDROP);
  wire w_ro = (wa == OFS_SPUSED) || (wa == OFS_DROPCNT) ||
              (wa == OFS_STATE) ||
              (w_al && (wa[AW-1 -: 2] == PORT_REGION) &&
               (wport < PW'(NPORT)) && (wsel == PSEL_USED));
  wire w_ok = w_preg || w_greg || w_ro;
  wire wr_do = wr_take && (w_preg || w_greg);

  // Read decode
  wire [AW-1:0] ra = s_axi_araddr;
  wire [PW-1:0] rport = ra[PORT_SHIFT +: PW];
  wire [2:0] rsel = ra[4:2];
  wire r_preg = (ra[1:0] == 2'h0) && (ra[AW-1 -: 2] == PORT_REGION) &&
                (rport < PW'(NPORT)) && (rsel <= PSEL_USED);
  wire [PW-1:0] ri = r_preg ? rport : '0;
  wire [31:0] r_port_word =
    (rsel == PSEL_RSV) ? 32'(rsv_q[ri]) :
    (rsel == PSEL_PON) ? 32'(pon_q[ri]) :
    (rsel == PSEL_POFF) ? 32'(poff_q[ri]) :
    (rsel == PSEL_PDROP) ? 32'(pdrop_q[ri]) :
    (rsel == PSEL_PSET) ? 32'(pset_q[ri]) :
    (rsel == PSEL_DROPEN) ? 32'(dropen_q[ri]) :
    32'(used_q[ri]);
  wire r_glob = (ra == OFS_GPON) || (ra == OFS_GPOFF) ||
                (ra == OFS_GDROP) || (ra == OFS_SPUSED) ||
                (ra == OFS_DROPCNT) || (ra == OFS_STATE);
  wire [31:0] r_glob_word =
    (ra == OFS_GPON) ? 32'(gpon_q) :
    (ra == OFS_GPOFF) ? 32'(gpoff_q) :
    (ra == OFS_GDROP) ? 32'(gdrop_q) :
    (ra == OFS_SPUSED) ? 32'(sp_used_q) :
    (ra == OFS_DROPCNT) ? drop_cnt_q :
    32'(gpause_q);
  wire [31:0] rd_word = r_preg ? r_port_word :
                        (r_glob ? r_glob_word : RST_WORD);

  // Ready pulses for one cycle; response stands until accepted
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= RESP_OKAY;
      s_axi_rdata <= RST_WORD;
    end else begin
      s_axi_awready <= wr_start;
      s_axi_wready <= wr_start;
      s_axi_arready <= rd_start;
      if (wr_take) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= w_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (rd_take) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_word;
        s_axi_rresp <= (r_preg || r_glob) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Global threshold registers; levels may change at any time
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gpon_q <= irm_thr_s'(RST_WORD);
      gpoff_q <= irm_thr_s'(RST_WORD);
      gdrop_q <= irm_thr_s'(RST_WORD);
    end else if (wr_do) begin
      if (wa == OFS_GPON) begin
        gpon_q <= to_thr(wmerge(gpon_q, s_axi_wdata, s_axi_wstrb));
      end
      if (wa == OFS_GPOFF) begin
        gpoff_q <= to_thr(wmerge(gpoff_q, s_axi_wdata, s_axi_wstrb));
      end
      if (wa == OFS_GDROP) begin
        gdrop_q <= to_thr(wmerge(gdrop_q, s_axi_wdata, s_axi_wstrb));
      end
    end
  end

  // ----------------------------------------------------------------
  // Per-port registers, counters and pause state
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < NPORT; gi++) begin : g_port
      wire wp = wr_do && w_preg && (wport == PW'(gi));
      wire inc = a_ok && (cell_in.port == PW'(gi));
      wire dec = f_ok && (free_in.port == PW'(gi));
      wire [CW-1:0] pool = pool_use(used_q[gi], rsv_q[gi]);
      wire last_here = a_last && (cell_in.port == PW'(gi));
      wire pp_set = last_here && hit_ge(pon_q[gi], pool);
      wire pp_clr = hit_lt(poff_q[gi], pool);
      // Pause state visible to the MACs; force ignores the enable
      wire pv_on = pset_q[gi].en && (ppause_q[gi] || gpause_q);
      wire pv_d = pset_q[gi].force_on ? pset_q[gi].pattern :
                  pv_on;

      // Port usage counts shared and reserved cells alike
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          used_q[gi] <= RST_CELLS;
        end else begin
          used_q[gi] <= used_q[gi] + CW'(inc) - CW'(dec);
        end
      end

      // Configuration; reserve changes corrupt counts on a busy port
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          rsv_q[gi] <= RST_CELLS;
          pon_q[gi] <= irm_thr_s'(RST_WORD);
          poff_q[gi] <= irm_thr_s'(RST_WORD);
          pdrop_q[gi] <= irm_thr_s'(RST_WORD);
          pset_q[gi] <= irm_pset_s'(RST_WORD);
          dropen_q[gi] <= 1'b0;
        end else if (wp) begin
          if (wsel == PSEL_RSV) begin
            rsv_q[gi] <= CW'(wmerge(32'(rsv_q[gi]), s_axi_wdata,
                                    s_axi_wstrb));
          end
          if (wsel == PSEL_PON) begin
            pon_q[gi] <= to_thr(wmerge(pon_q[gi], s_axi_wdata, s_axi_wstrb));
          end
          if (wsel == PSEL_POFF) begin
            poff_q[gi] <= to_thr(wmerge(poff_q[gi], s_axi_wdata,
                                        s_axi_wstrb));
          end
          if (wsel == PSEL_PDROP) begin
            pdrop_q[gi] <= to_thr(wmerge(pdrop_q[gi], s_axi_wdata,
                                         s_axi_wstrb));
          end
          if (wsel == PSEL_PSET && s_axi_wstrb[0]) begin
            pset_q[gi] <= irm_pset_s'({29'h0, s_axi_wdata[2:0]});
          end
          if (wsel == PSEL_DROPEN && s_axi_wstrb[0]) begin
            dropen_q[gi] <= s_axi_wdata[0];
          end
        end
      end

      // Hysteresis state and registered vector bit for the MACs
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          ppause_q[gi] <= 1'b0;
          pause_vec_q[gi] <= 1'b0;
        end else begin
          if (pp_set) begin
            ppause_q[gi] <= 1'b1;
          end else if (pp_clr) begin
            ppause_q[gi] <= 1'b0;
          end
          pause_vec_q[gi] <= pv_d;
        end
      end

      // Vector bit checks, every port
      AST_FORCE_PATTERN: assert property (
        @(posedge aclk) disable iff (!aresetn)
        pset_q[gi].force_on
        |=> pause_vec_q[gi] == $past(pset_q[gi].pattern))
        else $error("forced pattern not shown");

      AST_UNPAUSED_BOTH: assert property (
        @(posedge aclk) disable iff (!aresetn)
        !pset_q[gi].force_on && (ppause_q[gi] || gpause_q) && pset_q[gi].en
        |=> pause_vec_q[gi])
        else $error("port shown unpaused while a state is paused");

      AST_PAUSE_DISABLED: assert property (
        @(posedge aclk) disable iff (!aresetn)
        !pset_q[gi].force_on && !pset_q[gi].en |=> !pause_vec_q[gi])
        else $error("pause-disabled port shown paused");
    end
  endgenerate

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  AST_DROP_ONLY_AT_LAST: assert property (
    @(posedge aclk) disable iff (!aresetn)
    drop_q |-> $past(cell_in.valid) && $past(cell_in.last))
    else $error("drop without a last cell");

  AST_RESERVE_SHIELDS: assert property (
    @(posedge aclk) disable iff (!aresetn)
    a_last && rsv_left && !hit_gt(pdrop_q[a_idx], a_pool) |=> !drop_q)
    else $error("port with reserve left was dropped");

  AST_GLOBAL_DROP: assert property (
    @(posedge aclk) disable iff (!aresetn)
    a_last && dropen_q[a_idx] && !rsv_left &&
    gdrop_q.en && sp_used_q > gdrop_q.level |=> drop_q)
    else $error("global drop level ignored");

  AST_DROP_ENABLE: assert property (
    @(posedge aclk) disable iff (!aresetn)
    a_last && !dropen_q[a_idx] |=> !drop_q)
    else $error("drop on a port without drop enable");

  AST_GPAUSE_SET: assert property (
    @(posedge aclk) disable iff (!aresetn)
    a_last && gpon_q.en && sp_used_q >= gpon_q.level |=> gpause_q)
    else $error("global pause not set at on-level");

  AST_GPAUSE_HOLD: assert property (
    @(posedge aclk) disable iff (!aresetn)
    gpause_q && !(gpoff_q.en && (sp_used_q < gpoff_q.level || gpoff_q.trip))
    |=> gpause_q)
    else $error("global pause left before off-level");

  AST_DROP_COUNT: assert property (
    @(posedge aclk) disable iff (!aresetn)
    drop_q |-> drop_cnt_q == $past(drop_cnt_q) + 32'h1)
    else $error("drop not counted");

  AST_POOL_STEADY: assert property (
    @(posedge aclk) disable iff (!aresetn)
    !cell_in.valid && !free_in.valid |=> $stable(sp_used_q))
    else $error("pool count moved without cell traffic");

endmodule

// *** irm_mac_model.sv ***
// Pause-frame side model watching the pause state vector
`timescale 1ns/1ps
module irm_mac_model (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Pause state vector and frames issued
  input wire logic [irm_pkg::NPORT-1:0] pause_vec,
  output int frames
);
  import irm_pkg::*;
  logic [NPORT-1:0] last_q;
  // One pause frame per changed bit; frames are made here, not in the core
  always_ff @(posedge aclk) begin
    last_q <= pause_vec;
    if (!aresetn) frames <= 0;
    else frames <= frames + $countones(pause_vec ^ last_q);
  end
endmodule

// *** tb_irm_ingress_flow_ctrl.sv ***
// Self-checking bench for the ingress flow-control block
`timescale 1ns/1ps
module tb_irm_ingress_flow_ctrl;
  import irm_pkg::*;
  logic aclk = 0;
  logic aresetn = 0;
  irm_cell_s cell_in = '0;
  irm_free_s free_in = '0;
  logic decision_valid_q, drop_q, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic [PW-1:0] decision_port_q;
  logic [NPORT-1:0] pause_vec_q;
  logic [AW-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_arready, s_axi_rvalid;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = '0;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  int failures = 0, total_checks = 0, cycles = 0, frames;

  irm_ingress_flow_ctrl irm_ingress_flow_ctrl_inst (.aclk, .aresetn,
    .cell_in, .free_in, .decision_valid_q, .drop_q, .decision_port_q,
    .pause_vec_q, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready);
  irm_mac_model irm_mac_model_inst (.aclk, .aresetn,
    .pause_vec(pause_vec_q), .frames);

  // ----------------------------------------------------------------
  // Clock, timeout and reporting
  // ----------------------------------------------------------------
  initial forever #2.5 aclk = ~aclk;
  // Whole run needs well under this; a hang ends as a mismatch
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      results();
    end
  end
  task automatic results();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(string n, logic [31:0] s, logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      failures++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask

  // ----------------------------------------------------------------
  // Bus and cell drivers
  // ----------------------------------------------------------------
  function automatic logic [AW-1:0] pa(int p, logic [2:0] s);
    return {PORT_REGION, 11'h0} + AW'(p << PORT_SHIFT) + AW'({s, 2'b00});
  endfunction
  function automatic logic [31:0] thr(int l, logic en, logic tr);
    return {14'h0, tr, en, 2'h0, CW'(l)};
  endfunction
  // Address and data go out together; each is dropped once taken
  task automatic wr(logic [AW-1:0] a, logic [31:0] d);
    int n = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hf;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
    end while (!s_axi_bvalid && n < 100);
    s_axi_bready <= 0;
    chk("bvalid", s_axi_bvalid, 1);
    chk("bresp", s_axi_bresp, RESP_OKAY);
  endtask
  task automatic rd(logic [AW-1:0] a, logic [31:0] e,
                    logic [1:0] r = RESP_OKAY);
    int n = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 0;
    end while (!s_axi_rvalid && n < 100);
    s_axi_rready <= 0;
    chk("rdata", s_axi_rdata, e);
    chk("rresp", s_axi_rresp, r);
  endtask
  // Packet of n cells; decision must come only after the last one
  task automatic pkt(int p, int n, logic d);
    for (int i = 0; i < n; i++) begin
      @(posedge aclk);
      cell_in <= '{valid: 1'b1, last: (i == n - 1), port: PW'(p)};
      if (i > 0) chk("early", decision_valid_q, 0);
    end
    @(posedge aclk);
    cell_in <= '0;
    @(posedge aclk);
    chk("decision", {decision_valid_q, drop_q, decision_port_q},
        {1'b1, d, PW'(p)});
  endtask
  task automatic frees(int p, int n);
    for (int i = 0; i < n; i++) begin
      @(posedge aclk);
      free_in <= '{valid: 1'b1, port: PW'(p)};
    end
    @(posedge aclk);
    free_in <= '0;
    repeat (3) @(posedge aclk);
  endtask
  // Vector trails the state flop by one cycle
  task automatic pchk(int p, logic e);
    repeat (2) @(posedge aclk);
    chk("pause", pause_vec_q[p], e);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    rd(OFS_SPUSED, 0);
    rd(OFS_DROPCNT, 0);
    rd(OFS_STATE, 0);
    rd(pa(53, PSEL_RSV), 0, RESP_SLVERR);
    wr(OFS_SPUSED, 32'h5);
    rd(OFS_SPUSED, 0);
  endtask
  task automatic t_port_pause();
    wr(pa(3, PSEL_PON), thr(4, 1, 0));
    wr(pa(3, PSEL_POFF), thr(2, 1, 0));
    pkt(3, 5, 0);
    pchk(3, 0);
    frees(3, 5);
    wr(pa(3, PSEL_PSET), 32'h1);
    pkt(3, 3, 0);
    pchk(3, 0);
    pkt(3, 2, 0);
    pchk(3, 1);
    frees(3, 3);
    pchk(3, 1);
    frees(3, 1);
    pchk(3, 0);
    rd(pa(3, PSEL_USED), 1);
    frees(3, 1);
  endtask
  task automatic t_port_drop();
    wr(pa(5, PSEL_PDROP), thr(2, 1, 0));
    pkt(5, 4, 0);
    wr(pa(5, PSEL_DROPEN), 32'h1);
    pkt(5, 1, 1);
    rd(pa(5, PSEL_USED), 5);
    rd(OFS_DROPCNT, 1);
    frees(5, 5);
    pkt(5, 3, 0);
    frees(5, 3);
    wr(pa(5, PSEL_PDROP), thr(100, 1, 1));
    pkt(5, 1, 1);
    frees(5, 1);
    rd(OFS_DROPCNT, 2);
  endtask
  task automatic t_global();
    wr(pa(7, PSEL_RSV), 32'h4);
    wr(pa(7, PSEL_DROPEN), 32'h1);
    wr(pa(8, PSEL_DROPEN), 32'h1);
    wr(OFS_GDROP, thr(1, 1, 0));
    pkt(8, 2, 0);
    pkt(8, 1, 1);
    pkt(7, 1, 0);
    rd(OFS_SPUSED, 3);
    rd(pa(7, PSEL_USED), 1);
    wr(OFS_GPON, thr(3, 1, 0));
    wr(OFS_GPOFF, thr(2, 1, 0));
    wr(pa(7, PSEL_PSET), 32'h1);
    pkt(7, 1, 0);
    pchk(7, 1);
    pchk(3, 1);
    pchk(8, 0);
    rd(OFS_STATE, 1);
    frees(8, 1);
    pchk(7, 1);
    frees(8, 1);
    pchk(7, 0);
    rd(OFS_STATE, 0);
  endtask
  task automatic t_force();
    wr(pa(10, PSEL_PSET), 32'h6);
    pchk(10, 1);
    wr(pa(10, PSEL_PSET), 32'h2);
    pchk(10, 0);
    chk("frames", frames, 8);
  endtask

  // Reset for 8 cycles, then the scenarios in order
  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1;
    t_reset();
    t_port_pause();
    t_port_drop();
    t_global();
    t_force();
    results();
  end
endmodule
